// ==== logic/axrc_mode_sel.sv ====
`timescale 1ns/1ps
`default_nettype none

module axrc_mode_sel (
    // Configuration and drive capabilities.
    input wire axrc_pkg::axrc_cfg_t cfg,
    input wire axrc_pkg::axrc_caps_t caps,
    // Chosen transfer method.
    output axrc_pkg::axrc_mode_t mode
);

    // ==========================================================
    // Highest Ultra DMA mode in a mask, 2 to 4.
    function automatic logic [2:0] top_udma(input logic [5:0] m);
        logic [2:0] r;
        r = 3'h2;
        if (m[4]) begin
            r = 3'h4;
        end else if (m[3]) begin
            r = 3'h3;
        end
        return r;
    endfunction : top_udma

    // Highest PIO mode; mode 0 needs no bit.
    function automatic logic [2:0] top_pio(input logic [1:0] m);
        logic [2:0] r;
        r = 3'h0;
        if (m[1]) begin
            r = 3'h4;
        end else if (m[0]) begin
            r = 3'h3;
        end
        return r;
    endfunction : top_pio

    logic [5:0] udma_ok;
    logic udma_allowed;

    always_comb begin
        udma_ok = cfg.ultra_dma_mode_mask & caps.udma_supp & axrc_pkg::UDMA_USABLE;
        udma_allowed = caps.is_packet ? cfg.packet_dev_ultra_dma_en
                                      : cfg.disk_ultra_dma_en;
        mode.udma_mode = top_udma(udma_ok);
        mode.pio_mode = top_pio(cfg.programmed_io_mode_mask & caps.pio_supp);
        if (udma_allowed && (udma_ok != 6'h00)) begin
            mode.kind = axrc_pkg::KIND_UDMA;
        end else if (cfg.mwdma_en && caps.mwdma_supp) begin
            mode.kind = axrc_pkg::KIND_MWDMA;
        end else begin
            mode.kind = axrc_pkg::KIND_PIO;
        end
    end

endmodule : axrc_mode_sel

`default_nettype wire

// ==== logic/axrc_pkg.sv ====
package axrc_pkg;

    // ==========================================================
    // Register offsets.
    localparam logic [7:0] OFS_RESET_CFG = 8'h05;
    localparam logic [7:0] OFS_UDMA_CFG = 8'h06;
    localparam logic [7:0] OFS_PIO_CFG = 8'h07;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_MODE = 8'h11;

    // ==========================================================
    // Field positions.
    localparam int BIT_SOFT_RST_EN = 1;
    localparam int BIT_SKIP_PIN_RST = 0;
    localparam int BIT_DISK_UDMA_EN = 7;
    localparam int BIT_PKT_UDMA_EN = 6;
    localparam int BIT_MWDMA_EN = 2;
    localparam int BIT_STAT_BUSY = 7;
    localparam int BIT_STAT_FIRST = 6;

    // Only modes 2, 3 and 4 of the Ultra DMA mask are honoured.
    localparam logic [5:0] UDMA_USABLE = 6'h1c;

    // ==========================================================
    // Reset values.
    localparam logic [1:0] RST_RESET_CFG = 2'h3;
    localparam logic [7:0] RST_UDMA_CFG = 8'hd4;
    localparam logic [2:0] RST_PIO_CFG = 3'h7;

    // ==========================================================
    // Timing.
    localparam int CLK_PERIOD_NS = 40;
    localparam int HW_RST_NS = 25000;
    localparam int HW_RST_CYC = (HW_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Types.
    typedef enum logic [1:0] {
        KIND_PIO = 2'b00,
        KIND_MWDMA = 2'b01,
        KIND_UDMA = 2'b10
    } axrc_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HWRST = 2'b01,
        ST_SOFT = 2'b10,
        ST_SELECT = 2'b11
    } axrc_state_t;

    typedef struct packed {
        logic soft_reset_at_init_en;
        logic skip_pin_reset;
        logic disk_ultra_dma_en;
        logic packet_dev_ultra_dma_en;
        logic [5:0] ultra_dma_mode_mask;
        logic mwdma_en;
        logic [1:0] programmed_io_mode_mask;
    } axrc_cfg_t;

    typedef struct packed {
        logic is_packet;
        logic [5:0] udma_supp;
        logic mwdma_supp;
        logic [1:0] pio_supp;
    } axrc_caps_t;

    typedef struct packed {
        axrc_kind_t kind;
        logic [2:0] udma_mode;
        logic [2:0] pio_mode;
    } axrc_mode_t;

endpackage : axrc_pkg

// ==== logic/axrc_top.sv ====
// Summary of operation
// - Issue a soft reset during drive init only when its enable bit is one.
// - Skip bit set: pulse drive reset pin only on first init after chip reset.
// - Disk drive with Ultra DMA enabled and supported uses Ultra DMA.
// - Packet drive with Ultra DMA enabled and supported uses Ultra DMA.
// - Run the highest Ultra DMA mode 2..4 both enabled and supported.
// - Use multiword DMA when enabled and supported by the drive and Ultra DMA is not chosen.
// - Run the highest PIO mode 3 or 4 both enabled and supported.
// - PIO mode 0 is always available as the fallback.
`timescale 1ns/1ps
`default_nettype none

module axrc_top #(
    parameter int HW_RST_CYC = axrc_pkg::HW_RST_CYC
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic srst,
    // Register port.
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    // Initialization request and drive capabilities.
    input wire logic init_req,
    input wire axrc_pkg::axrc_caps_t drive_caps,
    // Drive reset controls.
    output logic drive_hw_reset_n,
    output logic soft_reset_pulse,
    // Result.
    output logic init_busy,
    output logic init_done,
    output axrc_pkg::axrc_mode_t xfer_mode
);

    // ==========================================================
    // Configuration registers.
    axrc_pkg::axrc_cfg_t cfg_r, cfg_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;

    always_comb begin
        cfg_nxt = cfg_r;
        if (wr_stb) begin
            unique case (addr)
                axrc_pkg::OFS_RESET_CFG: begin
                    cfg_nxt.soft_reset_at_init_en = wr_data[axrc_pkg::BIT_SOFT_RST_EN];
                    cfg_nxt.skip_pin_reset = wr_data[axrc_pkg::BIT_SKIP_PIN_RST];
                end
                axrc_pkg::OFS_UDMA_CFG: begin
                    cfg_nxt.disk_ultra_dma_en = wr_data[axrc_pkg::BIT_DISK_UDMA_EN];
                    cfg_nxt.packet_dev_ultra_dma_en = wr_data[axrc_pkg::BIT_PKT_UDMA_EN];
                    cfg_nxt.ultra_dma_mode_mask = wr_data[5:0];
                end
                axrc_pkg::OFS_PIO_CFG: begin
                    cfg_nxt.mwdma_en = wr_data[axrc_pkg::BIT_MWDMA_EN];
                    cfg_nxt.programmed_io_mode_mask = wr_data[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Initialization sequencer.
    localparam int CW = $clog2(HW_RST_CYC + 1);

    axrc_pkg::axrc_state_t state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic first_init_r, first_init_nxt;
    logic hw_rst_n_r, hw_rst_n_nxt;
    logic soft_r, soft_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    axrc_pkg::axrc_mode_t mode_r, mode_nxt;
    axrc_pkg::axrc_mode_t mode_pick;

    axrc_mode_sel u_sel (
        .cfg(cfg_r),
        .caps(drive_caps),
        .mode(mode_pick)
    );

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        first_init_nxt = first_init_r;
        hw_rst_n_nxt = hw_rst_n_r;
        soft_nxt = 1'b0;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        mode_nxt = mode_r;
        unique case (state_r)
            axrc_pkg::ST_IDLE: begin
                if (init_req) begin
                    busy_nxt = 1'b1;
                    first_init_nxt = 1'b0;
                    if (first_init_r || !cfg_r.skip_pin_reset) begin
                        state_nxt = axrc_pkg::ST_HWRST;
                        hw_rst_n_nxt = 1'b0;
                        cnt_nxt = CW'(HW_RST_CYC - 1);
                    end else begin
                        state_nxt = axrc_pkg::ST_SOFT;
                    end
                end
            end
            axrc_pkg::ST_HWRST: begin
                if (cnt_r == '0) begin
                    hw_rst_n_nxt = 1'b1;
                    state_nxt = axrc_pkg::ST_SOFT;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            axrc_pkg::ST_SOFT: begin
                soft_nxt = cfg_r.soft_reset_at_init_en;
                state_nxt = axrc_pkg::ST_SELECT;
            end
            axrc_pkg::ST_SELECT: begin
                mode_nxt = mode_pick;
                done_nxt = 1'b1;
                busy_nxt = 1'b0;
                state_nxt = axrc_pkg::ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Register read.
    always_comb begin
        rd_data_nxt = 8'h00;
        if (rd_stb) begin
            unique case (addr)
                axrc_pkg::OFS_RESET_CFG: begin
                    rd_data_nxt = {6'h00, cfg_r.soft_reset_at_init_en, cfg_r.skip_pin_reset};
                end
                axrc_pkg::OFS_UDMA_CFG: begin
                    rd_data_nxt = {cfg_r.disk_ultra_dma_en, cfg_r.packet_dev_ultra_dma_en,
                                   cfg_r.ultra_dma_mode_mask};
                end
                axrc_pkg::OFS_PIO_CFG: begin
                    rd_data_nxt = {5'h00, cfg_r.mwdma_en, cfg_r.programmed_io_mode_mask};
                end
                axrc_pkg::OFS_STATUS: begin
                    rd_data_nxt[axrc_pkg::BIT_STAT_BUSY] = busy_r;
                    rd_data_nxt[axrc_pkg::BIT_STAT_FIRST] = first_init_r;
                    rd_data_nxt[1:0] = mode_r.kind;
                end
                axrc_pkg::OFS_MODE: begin
                    rd_data_nxt = {1'b0, mode_r.udma_mode, 1'b0, mode_r.pio_mode};
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // State registers.
    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_r.soft_reset_at_init_en <= axrc_pkg::RST_RESET_CFG[axrc_pkg::BIT_SOFT_RST_EN];
            cfg_r.skip_pin_reset <= axrc_pkg::RST_RESET_CFG[axrc_pkg::BIT_SKIP_PIN_RST];
            cfg_r.disk_ultra_dma_en <= axrc_pkg::RST_UDMA_CFG[axrc_pkg::BIT_DISK_UDMA_EN];
            cfg_r.packet_dev_ultra_dma_en <= axrc_pkg::RST_UDMA_CFG[axrc_pkg::BIT_PKT_UDMA_EN];
            cfg_r.ultra_dma_mode_mask <= axrc_pkg::RST_UDMA_CFG[5:0];
            cfg_r.mwdma_en <= axrc_pkg::RST_PIO_CFG[axrc_pkg::BIT_MWDMA_EN];
            cfg_r.programmed_io_mode_mask <= axrc_pkg::RST_PIO_CFG[1:0];
            state_r <= axrc_pkg::ST_IDLE;
            cnt_r <= '0;
            first_init_r <= 1'b1;
            hw_rst_n_r <= 1'b1;
            soft_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            mode_r <= '0;
            rd_data_r <= 8'h00;
        end else begin
            cfg_r <= cfg_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            first_init_r <= first_init_nxt;
            hw_rst_n_r <= hw_rst_n_nxt;
            soft_r <= soft_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            mode_r <= mode_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign drive_hw_reset_n = hw_rst_n_r;
    assign soft_reset_pulse = soft_r;
    assign init_busy = busy_r;
    assign init_done = done_r;
    assign xfer_mode = mode_r;

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    a_soft_rst_on: assert property (
        (state_r == axrc_pkg::ST_SOFT && cfg_r.soft_reset_at_init_en) |=> soft_r ##1 done_r
    ) else $error("soft reset not issued while enabled");

    a_soft_rst_off: assert property (
        soft_r |-> $past(cfg_r.soft_reset_at_init_en) && $past(state_r == axrc_pkg::ST_SOFT)
    ) else $error("soft reset issued while disabled");

    a_pin_rst_skip: assert property (
        (state_r == axrc_pkg::ST_IDLE && init_req && !first_init_r && cfg_r.skip_pin_reset)
        |=> hw_rst_n_r [*3]
    ) else $error("drive reset pin pulsed while skipped");

    a_pin_rst_pulse: assert property (
        (state_r == axrc_pkg::ST_IDLE && init_req && (first_init_r || !cfg_r.skip_pin_reset))
        |=> !hw_rst_n_r && busy_r
    ) else $error("drive reset pin not pulsed");

    a_disk_udma_use: assert property (
        (done_r && !$past(drive_caps.is_packet) && $past(cfg_r.disk_ultra_dma_en)
         && (($past(cfg_r.ultra_dma_mode_mask) & $past(drive_caps.udma_supp)
              & axrc_pkg::UDMA_USABLE) != 6'h00))
        |-> mode_r.kind == axrc_pkg::KIND_UDMA
    ) else $error("disk drive not in ultra dma");

    a_pkt_udma_use: assert property (
        (done_r && $past(drive_caps.is_packet) && !$past(cfg_r.packet_dev_ultra_dma_en))
        |-> mode_r.kind != axrc_pkg::KIND_UDMA
    ) else $error("packet drive in ultra dma while disabled");

    a_udma_top_mode: assert property (
        (done_r && mode_r.kind == axrc_pkg::KIND_UDMA
         && $past(cfg_r.ultra_dma_mode_mask[4]) && $past(drive_caps.udma_supp[4]))
        |-> mode_r.udma_mode == 3'h4
    ) else $error("ultra dma mode not highest");

    a_mwdma_use: assert property (
        (done_r && $past(cfg_r.mwdma_en) && $past(drive_caps.mwdma_supp))
        |-> mode_r.kind != axrc_pkg::KIND_PIO
    ) else $error("multiword dma not used");

    a_pio_top_mode: assert property (
        (done_r && $past(cfg_r.programmed_io_mode_mask[1]) && $past(drive_caps.pio_supp[1]))
        |-> mode_r.pio_mode == 3'h4
    ) else $error("pio mode not highest");

    a_pio_floor: assert property (
        (done_r && (($past(cfg_r.programmed_io_mode_mask) & $past(drive_caps.pio_supp)) == 2'h0))
        |-> mode_r.pio_mode == 3'h0
    ) else $error("pio fallback not mode zero");

    a_pkt_udma_on: assert property (
        (done_r && $past(drive_caps.is_packet) && $past(cfg_r.packet_dev_ultra_dma_en)
         && (($past(cfg_r.ultra_dma_mode_mask) & $past(drive_caps.udma_supp)
              & axrc_pkg::UDMA_USABLE) != 6'h00))
        |-> mode_r.kind == axrc_pkg::KIND_UDMA
    ) else $error("packet drive not in ultra dma");

    a_udma_mode_set: assert property (
        (done_r && mode_r.kind == axrc_pkg::KIND_UDMA)
        |-> mode_r.udma_mode inside {3'h2, 3'h3, 3'h4}
    ) else $error("ultra dma mode outside 2 to 4");

    a_pio_mode_set: assert property (
        done_r |-> mode_r.pio_mode inside {3'h0, 3'h3, 3'h4}
    ) else $error("pio mode outside 0, 3 and 4");

    a_pin_rst_start: assert property (
        (state_r == axrc_pkg::ST_IDLE && init_req && (first_init_r || !cfg_r.skip_pin_reset))
        |=> cnt_r == CW'(HW_RST_CYC - 1)
    ) else $error("drive reset pin pulse length not loaded");

    a_pin_rst_end: assert property (
        (state_r == axrc_pkg::ST_HWRST && cnt_r == '0)
        |=> hw_rst_n_r && state_r == axrc_pkg::ST_SOFT
    ) else $error("drive reset pin not released");

    a_pin_low_state: assert property (
        !hw_rst_n_r |-> state_r == axrc_pkg::ST_HWRST
    ) else $error("drive reset pin low outside pin reset");

    a_mode_hold: assert property (
        !done_r |-> $stable(mode_r)
    ) else $error("transfer mode changed without init done");

    // ==========================================================
    // Coverage of the main scenarios.
    c_init_hw: cover property (
        (state_r == axrc_pkg::ST_IDLE && init_req && first_init_r) ##[1:700] done_r
    );
    c_init_skip: cover property (
        (state_r == axrc_pkg::ST_IDLE && init_req && !first_init_r && cfg_r.skip_pin_reset)
        ##3 done_r
    );
    c_udma_done: cover property (done_r && mode_r.kind == axrc_pkg::KIND_UDMA);
    c_pio_done: cover property (done_r && mode_r.kind == axrc_pkg::KIND_PIO);
    c_mwdma_done: cover property (done_r && mode_r.kind == axrc_pkg::KIND_MWDMA);

endmodule : axrc_top

`default_nettype wire

// ==== tb/axrc_drive_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module axrc_drive_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic srst,
    // Capabilities the drive reports.
    input wire axrc_pkg::axrc_caps_t caps_in,
    input wire logic init_busy,
    output axrc_pkg::axrc_caps_t drive_caps,
    // Reset activity seen at the drive.
    input wire logic drive_hw_reset_n,
    input wire logic soft_reset_pulse,
    output logic [15:0] pin_low_cyc,
    output logic [15:0] soft_cnt
);
    // ==========================================================
    // Reported capabilities change only while no init is running.
    always_ff @(posedge mclk) begin
        if (srst) begin
            drive_caps <= '0;
        end else if (!init_busy) begin
            drive_caps <= caps_in;
        end
    end

    // ==========================================================
    // Counts reset activity so each init can be judged by difference.
    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_low_cyc <= 16'h0000;
            soft_cnt <= 16'h0000;
        end else begin
            pin_low_cyc <= pin_low_cyc + {15'h0000, !drive_hw_reset_n};
            soft_cnt <= soft_cnt + {15'h0000, soft_reset_pulse};
        end
    end
endmodule : axrc_drive_model

`default_nettype wire

// ==== tb/axrc_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end

module axrc_top_bench;
    localparam int HWC = 4;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic init_req = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] rd_data;
    axrc_pkg::axrc_caps_t caps_in = '0;
    axrc_pkg::axrc_caps_t drive_caps;
    axrc_pkg::axrc_mode_t xfer_mode;
    logic drive_hw_reset_n;
    logic soft_reset_pulse;
    logic init_busy;
    logic init_done;
    logic [15:0] pin_low_cyc;
    logic [15:0] soft_cnt;
    int n_errors = 0;
    int checks_done = 0;

    always #20 mclk = ~mclk;

    axrc_top #(.HW_RST_CYC(HWC)) u_dut (
        .mclk(mclk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data), .init_req(init_req), .drive_caps(drive_caps),
        .drive_hw_reset_n(drive_hw_reset_n), .soft_reset_pulse(soft_reset_pulse),
        .init_busy(init_busy), .init_done(init_done), .xfer_mode(xfer_mode)
    );

    axrc_drive_model u_drive (
        .mclk(mclk), .srst(srst), .caps_in(caps_in), .init_busy(init_busy),
        .drive_caps(drive_caps), .drive_hw_reset_n(drive_hw_reset_n),
        .soft_reset_pulse(soft_reset_pulse), .pin_low_cyc(pin_low_cyc), .soft_cnt(soft_cnt)
    );

    // ==========================================================
    // Closing report.
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // ==========================================================
    // Register port cycles.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr_stb <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        `CHK("rd_data", e, rd_data)
        @(posedge mclk);
        #1;
        `CHK("rd_data idle", 8'h00, rd_data)
    endtask : rd

    // ==========================================================
    // One drive initialization with the expected reset activity.
    task automatic init(input logic [15:0] e_pin, input logic [15:0] e_soft);
        logic [15:0] p0;
        logic [15:0] s0;
        int i;
        p0 = pin_low_cyc;
        s0 = soft_cnt;
        @(posedge mclk);
        init_req <= 1'b1;
        @(posedge mclk);
        init_req <= 1'b0;
        #1;
        `CHK("init_busy", 1'b1, init_busy)
        for (i = 0; i < 40; i++) begin
            #1;
            if (init_done === 1'b1) break;
            @(posedge mclk);
        end
        if (i == 40) begin
            n_errors++;
            summarize();
        end else begin
            `CHK("init_busy end", 1'b0, init_busy)
            `CHK("pin low cycles", e_pin, pin_low_cyc - p0)
            `CHK("soft reset pulses", e_soft, soft_cnt - s0)
        end
    endtask : init

    // Mode choice; the Ultra DMA field only matters when Ultra DMA is chosen.
    task automatic mchk(input logic [7:0] c06, input logic [7:0] c07,
                        input axrc_pkg::axrc_caps_t cp, input axrc_pkg::axrc_mode_t e);
        logic [7:0] m;
        wr(axrc_pkg::OFS_UDMA_CFG, c06);
        wr(axrc_pkg::OFS_PIO_CFG, c07);
        caps_in <= cp;
        init(16'h0000, 16'h0001);
        m = (e.kind == axrc_pkg::KIND_UDMA) ? 8'hff : 8'hc7;
        `CHK("xfer_mode", e & m, xfer_mode & m)
    endtask : mchk

    // ==========================================================
    // Main sequence.
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        rd(8'h05, 8'h03);
        rd(8'h06, 8'hd4);
        rd(8'h07, 8'h07);
        rd(8'h10, 8'h40);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00);
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h03);
        $display("test registers done");
        init(HWC, 16'h0001);
        init(16'h0000, 16'h0001);
        wr(8'h05, 8'h00);
        init(HWC, 16'h0000);
        wr(8'h05, 8'h02);
        init(HWC, 16'h0001);
        wr(8'h05, 8'h03);
        $display("test reset methods done");
        mchk(8'hd4, 8'h07, {1'b0, 6'h1c, 1'b1, 2'b11}, {2'd2, 3'd4, 3'd4});
        rd(8'h11, {1'b0, 3'd4, 1'b0, 3'd4});
        rd(8'h10, 8'h02);
        mchk(8'hd4, 8'h07, {1'b0, 6'h0c, 1'b1, 2'b11}, {2'd2, 3'd2, 3'd4});
        mchk(8'h5c, 8'h07, {1'b0, 6'h1c, 1'b1, 2'b01}, {2'd1, 3'd0, 3'd3});
        mchk(8'h5c, 8'h07, {1'b1, 6'h08, 1'b0, 2'b10}, {2'd2, 3'd3, 3'd4});
        mchk(8'h9c, 8'h07, {1'b1, 6'h1c, 1'b1, 2'b10}, {2'd1, 3'd0, 3'd4});
        mchk(8'hd4, 8'h07, {1'b0, 6'h03, 1'b1, 2'b00}, {2'd1, 3'd0, 3'd0});
        mchk(8'h80, 8'h03, {1'b0, 6'h3f, 1'b1, 2'b00}, {2'd0, 3'd0, 3'd0});
        mchk(8'h00, 8'h01, {1'b0, 6'h1c, 1'b1, 2'b11}, {2'd0, 3'd0, 3'd3});
        mchk(8'h00, 8'h02, {1'b0, 6'h1c, 1'b0, 2'b01}, {2'd0, 3'd0, 3'd0});
        $display("test mode choice done");
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd(8'h10, 8'h40);
        rd(8'h11, 8'h00);
        init(HWC, 16'h0001);
        init(16'h0000, 16'h0001);
        $display("test second reset done");
        summarize();
    end
endmodule : axrc_top_bench

`default_nettype wire
